// >>> hw/pmt_pkg.sv
// constants and divider table for the periodic modulo tick counter
package pmt_pkg;

   // ********************************************************
   // bus geometry
   // ********************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int IDX_W = 14;

   // ********************************************************
   // register indices (byte address is four times the index)
   // ********************************************************
   localparam logic [IDX_W-1:0] IDX_MOD_HI = 14'h306C;
   localparam logic [IDX_W-1:0] IDX_MOD_LO = 14'h306D;
   localparam logic [IDX_W-1:0] IDX_CNT_HI = 14'h306E;
   localparam logic [IDX_W-1:0] IDX_CNT_LO = 14'h306F;
   localparam logic [IDX_W-1:0] IDX_STATUS = 14'h3070;
   localparam logic [IDX_W-1:0] IDX_MASK = 14'h3071;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 14'h3072;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int FLAG_BIT = 0;
   localparam int ENABLE_BIT = 0;
   localparam int SRC_LSB = 6;
   localparam int SRC_MSB = 7;
   localparam int DIV_LSB = 0;
   localparam int DIV_MSB = 2;

   // ********************************************************
   // reset values and codes
   // ********************************************************
   localparam logic [15:0] MOD_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [1:0] SRC_RESET = 2'h0;
   localparam logic [2:0] DIV_RESET = 3'h0;
   localparam logic [2:0] DIV_OFF = 3'h0;
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_LPO = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int NUM_OSC = 2;

   // ********************************************************
   // divider ratios in source edges
   // ********************************************************
   localparam logic [11:0] DIV_BIN_BASE = 12'h001;
   localparam logic [11:0] DIV_X1_BASE = 12'h080;
   localparam logic [11:0] DIV_DEC_SHORT = 12'h064;
   localparam logic [11:0] DIV_DEC_LONG = 12'h3E8;
   localparam logic [2:0] DIV_CODE_SHORT = 3'h6;
   localparam logic [2:0] DIV_CODE_LONG = 3'h7;

endpackage

// >>> hw/pmt_top.sv
// periodic modulo tick counter with an axi4-lite register slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module pmt_top
   import pmt_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_ext_osc,
   input wire logic i_onchip_osc,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_irq
);

   // ********************************************************
   // declarations
   // ********************************************************
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
   logic [1:0] bresp_r, rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_byte_r;
   logic w_lane_r;
   logic [NUM_OSC-1:0] osc_s1_r, osc_s2_r, osc_s3_r;
   logic [NUM_OSC-1:0] osc_edge;
   logic [15:0] mod_buf_r, cmp_r, cnt_r;
   logic [11:0] ps_cnt_r;
   logic [11:0] ps_period;
   logic [1:0] src_sel_r;
   logic [2:0] div_sel_r;
   logic flag_r, irq_en_r;
   logic flag_nxt, irq_en_nxt;
   logic wr_go, wr_hit, wr_mod, wr_cfg, wr_status, wr_mask;
   logic [IDX_W-1:0] wr_idx, rd_idx;
   logic [1:0] new_src;
   logic [2:0] new_div;
   logic cfg_change, div_start, src_edge, tick, wrap, clr_cnt;
   logic [7:0] rd_byte;
   logic rd_hit;

   assign o_awready = awready_r;
   assign o_wready = wready_r;
   assign o_bvalid = bvalid_r;
   assign o_bresp = bresp_r;
   assign o_arready = arready_r;
   assign o_rvalid = rvalid_r;
   assign o_rdata = rdata_r;
   assign o_rresp = rresp_r;
   assign o_irq = irq_r;

   // ********************************************************
   // oscillator synchronisers
   // ********************************************************
   // edges synchronised first
   generate
      for (genvar g = 0; g < NUM_OSC; g++) begin : g_osc
         always_ff @(posedge i_clock) begin
            if (i_reset) begin
               osc_s1_r[g] <= 1'b0;
               osc_s2_r[g] <= 1'b0;
               osc_s3_r[g] <= 1'b0;
            end else begin
               osc_s1_r[g] <= (g == 0) ? i_ext_osc : i_onchip_osc;
               osc_s2_r[g] <= osc_s1_r[g];
               osc_s3_r[g] <= osc_s2_r[g];
            end
         end
         assign osc_edge[g] = osc_s2_r[g] & ~osc_s3_r[g];
      end
   endgenerate

   // ********************************************************
   // write channel capture
   // ********************************************************
   // address and data are taken in either order; the write is done
   // once both are held and no response is outstanding
   assign wr_go = !awready_r && !wready_r && !bvalid_r;
   assign wr_idx = aw_addr_r[ADDR_W-1:2];
   assign wr_mod = wr_go && w_lane_r &&
                   (wr_idx == IDX_MOD_HI || wr_idx == IDX_MOD_LO);
   assign wr_cfg = wr_go && w_lane_r && wr_idx == IDX_CONFIG;
   assign wr_status = wr_go && w_lane_r && wr_idx == IDX_STATUS;
   assign wr_mask = wr_go && w_lane_r && wr_idx == IDX_MASK;
   assign wr_hit = wr_idx inside {IDX_MOD_HI, IDX_MOD_LO, IDX_CNT_HI,
                                  IDX_CNT_LO, IDX_STATUS, IDX_MASK,
                                  IDX_CONFIG};

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         aw_addr_r <= '0;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else begin
         if (awready_r && i_awvalid) begin
            awready_r <= 1'b0;
            aw_addr_r <= i_awaddr;
         end
         if (wready_r && i_wvalid) begin
            wready_r <= 1'b0;
            w_byte_r <= i_wdata[7:0];
            w_lane_r <= i_wstrb[0];
         end
         if (wr_go) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && i_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ********************************************************
   // read channel
   // ********************************************************
   assign rd_idx = i_araddr[ADDR_W-1:2];

   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      unique case (rd_idx)
         IDX_MOD_HI: rd_byte = mod_buf_r[15:8];
         IDX_MOD_LO: rd_byte = mod_buf_r[7:0];
         IDX_CNT_HI: rd_byte = cnt_r[15:8];
         IDX_CNT_LO: rd_byte = cnt_r[7:0];
         IDX_STATUS: rd_byte[FLAG_BIT] = flag_r;
         IDX_MASK: rd_byte[ENABLE_BIT] = irq_en_r;
         IDX_CONFIG: begin
            rd_byte[SRC_MSB:SRC_LSB] = src_sel_r;
            rd_byte[DIV_MSB:DIV_LSB] = div_sel_r;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (arready_r && i_arvalid) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h000000, rd_byte};
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && i_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ********************************************************
   // configuration
   // ********************************************************
   assign new_src = w_byte_r[SRC_MSB:SRC_LSB];
   assign new_div = w_byte_r[DIV_MSB:DIV_LSB];
   assign cfg_change = wr_cfg &&
                       (new_src != src_sel_r || new_div != div_sel_r);
   assign div_start = cfg_change && new_div != DIV_OFF;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         src_sel_r <= SRC_RESET;
         div_sel_r <= DIV_RESET;
      end else if (wr_cfg) begin
         src_sel_r <= new_src;
         div_sel_r <= new_div;
      end
   end

   // ********************************************************
   // divider table
   // ********************************************************
   // decimal ratios sit on the two top codes of the x1 table only
   function automatic logic [11:0] pmt_div_period(input logic [2:0] code,
                                                   input logic src_lsb);
      logic [11:0] p;
      p = DIV_BIN_BASE;
      if (!src_lsb) begin
         p = DIV_BIN_BASE << (code - 3'h1);
      end else begin
         unique case (code)
            DIV_CODE_SHORT: p = DIV_DEC_SHORT;
            DIV_CODE_LONG: p = DIV_DEC_LONG;
            default: p = DIV_X1_BASE << (code - 3'h1);
         endcase
      end
      return p;
   endfunction

   // ********************************************************
   // prescaler
   // ********************************************************
   // source routing
   always_comb begin
      unique case (src_sel_r)
         SRC_EXT: src_edge = osc_edge[0];
         SRC_LPO: src_edge = osc_edge[1];
         default: src_edge = 1'b1;
      endcase
   end

   assign ps_period = pmt_div_period(div_sel_r, src_sel_r[0]);
   assign tick = div_sel_r != DIV_OFF && src_edge &&
                 ps_cnt_r == ps_period - 12'h001 && !cfg_change;

   always_ff @(posedge i_clock) begin
      if (i_reset || cfg_change || div_sel_r == DIV_OFF) begin
         ps_cnt_r <= 12'h000;
      end else if (src_edge) begin
         ps_cnt_r <= tick ? 12'h000 : ps_cnt_r + 12'h001;
      end
   end

   // ********************************************************
   // modulo buffer and compare value
   // ********************************************************
   // modulo reset to zero
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         mod_buf_r <= MOD_RESET;
      end else if (wr_mod && wr_idx == IDX_MOD_HI) begin
         mod_buf_r[15:8] <= w_byte_r;
      end else if (wr_mod) begin
         mod_buf_r[7:0] <= w_byte_r;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         cmp_r <= MOD_RESET;
      end else if (wrap || div_start) begin
         cmp_r <= mod_buf_r;
      end
   end

   // ********************************************************
   // main counter
   // ********************************************************
   // clear sources
   assign clr_cnt = wr_mod || cfg_change;
   assign wrap = tick && cnt_r == cmp_r && !clr_cnt;

   always_ff @(posedge i_clock) begin
      if (i_reset || clr_cnt) begin
         cnt_r <= CNT_RESET;
      end else if (wrap) begin
         cnt_r <= CNT_RESET;
      end else if (tick) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // ********************************************************
   // flag, enable and interrupt
   // ********************************************************
   // flag on modulo-to-zero step
   assign flag_nxt = wrap ||
                     (flag_r && !(wr_status && w_byte_r[FLAG_BIT]));
   assign irq_en_nxt = wr_mask ? w_byte_r[ENABLE_BIT] : irq_en_r;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         irq_en_r <= irq_en_nxt;
         irq_r <= flag_nxt && irq_en_nxt;
      end
   end

   // ********************************************************
   // assertions
   // ********************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   wrap_zero_a: assert property (
      wrap |=> cnt_r == 16'h0000 && flag_r)
      else $error("match did not wrap count and set flag");
   mod_zero_a: assert property (
      tick && cmp_r == 16'h0000 && !clr_cnt |=> flag_r)
      else $error("zero modulo tick did not set flag");
   count_step_a: assert property (
      tick && !wrap && !clr_cnt |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step by one");
   clr_count_a: assert property (clr_cnt |=> cnt_r == 16'h0000)
      else $error("counter not cleared by write");
   presc_clear_a: assert property (
      cfg_change |=> ps_cnt_r == 12'h000 && cnt_r == 16'h0000)
      else $error("config change did not clear counters");
   presc_off_a: assert property (div_sel_r == DIV_OFF |-> !tick)
      else $error("tick while prescaler off");
   cmp_hold_a: assert property (
      !wrap && !div_start |=> cmp_r == $past(cmp_r))
      else $error("compare value changed without wrap or start");
   irq_level_a: assert property (o_irq == (flag_r && irq_en_r))
      else $error("interrupt does not follow flag and enable");
   flag_clear_a: assert property (
      wr_status && w_byte_r[FLAG_BIT] && !wrap |=> !flag_r && !o_irq)
      else $error("write one did not clear flag");
   zero_write_a: assert property (
      wr_status && !w_byte_r[FLAG_BIT] && flag_r |=> flag_r)
      else $error("write zero changed flag");
   count_read_a: assert property (
      arready_r && i_arvalid && rd_idx == IDX_CNT_LO
      |=> rdata_r[7:0] == $past(cnt_r[7:0]))
      else $error("count read does not match counter");
   bus_rate_a: assert property (
      src_sel_r[1] && !src_sel_r[0] && div_sel_r == 3'h1 && !cfg_change
      |-> tick)
      else $error("bus clock divide by one missed a tick");

   cov_wrap_c: cover property (wrap ##1 o_irq);
   cov_clear_c: cover property (flag_r ##1 wr_status ##1 !flag_r);
   cov_lpo_c: cover property (src_sel_r == SRC_LPO && tick);
   cov_start_c: cover property (div_start ##1 cmp_r != 16'h0000);

endmodule // pmt_top

`default_nettype wire

// >>> test/pmt_top_tb_top.sv
// self-checking bench for the periodic modulo tick counter
`timescale 1ns/1ns
`default_nettype none

module pmt_top_tb_top
   import pmt_pkg::*;
;
   logic i_clock, i_reset, i_ext_osc, i_onchip_osc;
   logic [ADDR_W-1:0] i_awaddr, i_araddr;
   logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [DATA_W-1:0] i_wdata, o_rdata;
   logic [3:0] i_wstrb;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] rd;
   logic [1:0] rs;
   int error_cnt, n_compared;
   // ratios of the x1 table, codes 1..7
   int x1_div [7] = '{128, 256, 512, 1024, 2048, 100, 1000};

   pmt_top u_pmt_top (.i_clock(i_clock), .i_reset(i_reset),
      .i_ext_osc(i_ext_osc), .i_onchip_osc(i_onchip_osc),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .o_irq(o_irq));

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // ***************************************************
   // reporting
   // ***************************************************
   task automatic results;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic timeout(input string nm);
      error_cnt++;
      $display("MISMATCH %s expected answer seen timeout", nm);
      results();
   endtask

   // ***************************************************
   // axi4-lite master
   // ***************************************************
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                     output logic [1:0] resp);
      int n;
      @(posedge i_clock);
      i_awaddr <= {idx, 2'b00};
      i_wdata <= {24'h000000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      resp = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clock);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid) begin
            resp = o_bresp;
            i_bready <= 1'b0;
            break;
         end
      end
      if (n == 50) timeout("write");
   endtask

   task automatic rdr(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
      int n;
      @(posedge i_clock);
      i_araddr <= {idx, 2'b00};
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      d = 32'hFFFFFFFF;
      resp = 2'h3;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clock);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid) begin
            d = o_rdata;
            resp = o_rresp;
            i_rready <= 1'b0;
            break;
         end
      end
      if (n == 50) timeout("read");
   endtask

   task automatic wok(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      cmp("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask

   task automatic chk(input string nm, input logic [IDX_W-1:0] idx,
                      input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rdr(idx, d, r);
      cmp(nm, {24'h000000, exp}, d);
      cmp("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge i_clock);
      cmp("irq", {31'h0, exp}, {31'h0, o_irq});
   endtask

   // slow source edges; the tail covers the synchroniser latency
   task automatic pulse(input bit onchip, input int n);
      repeat (n) begin
         @(posedge i_clock);
         if (onchip) i_onchip_osc <= 1'b1;
         else i_ext_osc <= 1'b1;
         repeat (3) @(posedge i_clock);
         i_onchip_osc <= 1'b0;
         i_ext_osc <= 1'b0;
         repeat (3) @(posedge i_clock);
      end
      repeat (6) @(posedge i_clock);
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      {i_ext_osc, i_onchip_osc, i_awvalid, i_wvalid} = 4'h0;
      {i_bready, i_arvalid, i_rready} = 3'h0;
      i_awaddr = 16'h0000;
      i_araddr = 16'h0000;
      i_wdata = 32'h00000000;
      i_wstrb = 4'h1;
      i_reset = 1'b1;
      error_cnt = 0;
      n_compared = 0;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      chk("compare_high", IDX_MOD_HI, 8'h00);
      chk("compare_low", IDX_MOD_LO, 8'h00);
      chk("tick_count_high", IDX_CNT_HI, 8'h00);
      chk("tick_count_low", IDX_CNT_LO, 8'h00);
      chk("config", IDX_CONFIG, 8'h00);
      chk("status", IDX_STATUS, 8'h00);
      chk("mask", IDX_MASK, 8'h00);
      rdr(14'h0000, rd, rs);
      cmp("unmapped rdata", 32'h00000000, rd);
      cmp("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      wr(14'h0000, 8'h5A, rs);
      cmp("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      pulse(0, 3);
      chk("count while off", IDX_CNT_LO, 8'h00);
      wok(IDX_MOD_LO, 8'h03);
      wok(IDX_CONFIG, 8'h01);
      pulse(0, 3);
      chk("count ext", IDX_CNT_LO, 8'h03);
      chk("no flag yet", IDX_STATUS, 8'h00);
      wok(IDX_CNT_LO, 8'h55);
      wok(IDX_CNT_HI, 8'hAA);
      chk("count after write", IDX_CNT_LO, 8'h03);
      chk("count high", IDX_CNT_HI, 8'h00);
      pulse(0, 1);
      chk("count wrap", IDX_CNT_LO, 8'h00);
      chk("flag on wrap", IDX_STATUS, 8'h01);
      irq_is(1'b0);
      wok(IDX_MASK, 8'h01);
      irq_is(1'b1);
      wok(IDX_STATUS, 8'h00);
      chk("flag kept", IDX_STATUS, 8'h01);
      wok(IDX_STATUS, 8'h01);
      chk("flag cleared", IDX_STATUS, 8'h00);
      irq_is(1'b0);
      pulse(0, 2);
      wok(IDX_MOD_LO, 8'h01);
      chk("count on mod write", IDX_CNT_LO, 8'h00);
      chk("compare_low", IDX_MOD_LO, 8'h01);
      pulse(0, 3);
      chk("old compare", IDX_CNT_LO, 8'h03);
      pulse(0, 2);
      chk("new compare", IDX_CNT_LO, 8'h01);
      pulse(0, 1);
      chk("wrap new", IDX_CNT_LO, 8'h00);
      pulse(0, 1);
      wok(IDX_CONFIG, 8'h01);
      chk("same config", IDX_CNT_LO, 8'h01);
      wok(IDX_CONFIG, 8'h02);
      chk("changed divider", IDX_CNT_LO, 8'h00);
      wok(IDX_MOD_HI, 8'hFF);
      wok(IDX_MOD_LO, 8'hFF);
      chk("compare_high", IDX_MOD_HI, 8'hFF);
      chk("compare_low", IDX_MOD_LO, 8'hFF);
      for (int s = 0; s < 2; s++) begin
         for (int c = 1; c < 8; c++) begin
            wok(IDX_CONFIG, {1'b0, s[0], 3'b000, c[2:0]});
            pulse(s[0], (s == 0) ? (1 << (c - 1)) - 1 : x1_div[c-1] - 1);
            chk("before tick", IDX_CNT_LO, 8'h00);
            pulse(s[0], 1);
            chk("after tick", IDX_CNT_LO, 8'h01);
         end
      end
      // bus clock through the x1 table: divide by 128
      wok(IDX_CONFIG, 8'hC1);
      repeat (300) @(posedge i_clock);
      chk("bus clock count", IDX_CNT_LO, 8'h02);
      wok(IDX_MOD_HI, 8'h00);
      wok(IDX_MOD_LO, 8'h00);
      wok(IDX_CONFIG, 8'h81);
      wok(IDX_STATUS, 8'h01);
      chk("flag every tick", IDX_STATUS, 8'h01);
      chk("count at zero", IDX_CNT_LO, 8'h00);
      irq_is(1'b1);
      @(posedge i_clock);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      chk("compare_low", IDX_MOD_LO, 8'h00);
      chk("config", IDX_CONFIG, 8'h00);
      chk("tick_count_low", IDX_CNT_LO, 8'h00);
      chk("status", IDX_STATUS, 8'h00);
      results();
   end

endmodule // pmt_top_tb_top

`default_nettype wire
